//--- bench/irqfs_cpu_model.sv
`timescale 1ns/10ps
module irqfs_cpu_model (
  input logic core_clk, srst, entry_strobe, hold_clr,
  input logic [3:0] mask,
  input logic [31:0] next_status,
  output logic [31:0] cpu_status, cpu_pc, vector_base,
  output logic insn_boundary
);
  assign vector_base = 32'h80001000;
  always @(posedge core_clk) begin
    if (srst) begin
      cpu_status <= '0;
      cpu_pc <= '0;
      insn_boundary <= 1'b0;
    end else begin
      cpu_pc <= cpu_pc + 32'h2;
      // Two-cycle instructions, so entry often has to wait
      insn_boundary <= ~insn_boundary;
      if (entry_strobe) cpu_status <= next_status;
      else if (hold_clr) cpu_status[28] <= 1'b0;
      cpu_status[7:4] <= mask;
    end
  end
endmodule

//--- bench/irqfs_properties.sv
`timescale 1ns/10ps
module irqfs_properties (
  input logic core_clk, srst, clk_en, converter_done_req, reg_rd, insn_boundary,
  input logic cpu_irq_req, pending_indicator_pin_n, entry_strobe,
  input logic [3:0] dma_end_req, infrared_req, fifo_serial_req, reg_addr,
  input logic [31:0] reg_rdata, cpu_status, cpu_pc, vector_base, next_status, entry_target,
  input logic [31:0] saved_status_register, saved_program_counter
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  pin_tracks_accept_a: assert property (pending_indicator_pin_n != cpu_irq_req)
    else $error("pin disagrees with request");
  entry_target_a: assert property (entry_strobe |-> entry_target == $past(vector_base) + 32'h600)
    else $error("bad entry target");
  status_saved_a: assert property (entry_strobe |-> saved_status_register == $past(cpu_status))
    else $error("bad saved status");
  pc_saved_a: assert property (entry_strobe |-> saved_program_counter == $past(cpu_pc))
    else $error("bad saved pc");
  entry_status_a: assert property (entry_strobe |-> next_status == ($past(cpu_status) | 32'h70000000))
    else $error("bad entry status");
  entry_cause_a: assert property (entry_strobe |-> $past(clk_en && cpu_irq_req && insn_boundary && !cpu_status[28]))
    else $error("entry without cause");
  accept_cause_a: assert property ($rose(cpu_irq_req) |->
    $past(|{dma_end_req, infrared_req, converter_done_req, fifo_serial_req}, 2))
    else $error("accept without request");
  full_mask_a: assert property ($past(clk_en && cpu_status[7:4] == 4'hf) |-> !cpu_irq_req)
    else $error("accept above full mask");
  reserved_zero_a: assert property ($past(reg_rd && reg_addr == 4'h1) |-> reg_rdata[31:5] == 27'h0)
    else $error("reserved bits not zero");
endmodule
bind irqfs_sequencer irqfs_properties chk (.*);

//--- bench/irqfs_sequencer_tb.sv
`timescale 1ns/10ps
module irqfs_sequencer_tb;
  logic core_clk = 0, srst = 1, clk_en = 1, converter_done_req = 0, reg_wr = 0, reg_rd = 0, hold_clr = 0;
  logic [3:0] dma_end_req = '0, infrared_req = '0, fifo_serial_req = '0, reg_addr = '0, mask = 4'hf;
  logic [31:0] reg_wdata = '0, reg_rdata, cpu_status, cpu_pc, vector_base, next_status, entry_target;
  logic [31:0] saved_status_register, saved_program_counter;
  logic cpu_irq_req, pending_indicator_pin_n, entry_strobe, irq_out, insn_boundary;
  int num_errors = 0, checks_done = 0, cyc = 0;
  irqfs_sequencer uut (.*);
  irqfs_cpu_model cpu (.*);
  initial forever #5 core_clk = ~core_clk;
  task chk(input logic [31:0] s, e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task summarize;
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, e);
  endtask
  task settle(input int n, input logic [31:0] pin);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
    chk(pending_indicator_pin_n, pin);
  endtask
  task wait_entry;
    int n;
    n = 0;
    while (entry_strobe !== 1'b1 && n < 40) begin
      @(negedge core_clk);
      n++;
    end
    chk(n < 40, 1'b1);
  endtask
  task t_flags;
    rd(4'h0, 32'h0);
    rd(4'h1, 32'h0);
    @(posedge core_clk);
    infrared_req <= 4'ha;
    dma_end_req <= 4'h5;
    fifo_serial_req <= 4'hc;
    converter_done_req <= 1'b1;
    wr(4'h1, 32'hff);
    rd(4'h0, 32'ha5);
    rd(4'h1, 32'h1c);
    rd(4'hf, 32'h0);
    chk(cpu_irq_req, 1'b0);
    @(posedge core_clk);
    {infrared_req, dma_end_req, fifo_serial_req, converter_done_req} <= '0;
    rd(4'h0, 32'h0);
  endtask
  task t_accept;
    // Converter ties with infrared at level 5, DMA sits at 3
    wr(4'h2, 32'h553);
    @(posedge core_clk);
    mask <= 4'h4;
    dma_end_req <= 4'h1;
    infrared_req <= 4'h6;
    converter_done_req <= 1'b1;
    wait_entry;
    rd(4'h5, 32'h4a0);
    rd(4'h6, 32'h4a0);
    chk(pending_indicator_pin_n, 1'b0);
    chk(entry_target, vector_base + 32'h600);
    @(posedge core_clk);
    mask <= 4'h5;
    settle(3, 1'b1);
    @(posedge core_clk);
    mask <= 4'h4;
    infrared_req <= 4'h0;
    rd(4'h0, 32'h1);
    settle(4, 1'b0);
    @(posedge core_clk);
    hold_clr <= 1'b1;
    @(posedge core_clk);
    hold_clr <= 1'b0;
    wait_entry;
    rd(4'h5, 32'h500);
    @(posedge core_clk);
    converter_done_req <= 1'b0;
    mask <= 4'h3;
    settle(4, 1'b1);
    @(posedge core_clk);
    mask <= 4'h2;
    settle(4, 1'b0);
  endtask
  task t_irq;
    wr(4'h8, 32'h2);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk(irq_out, 1'b1);
    wr(4'h7, 32'h2);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk(irq_out, 1'b0);
  endtask
  // Frozen core must ignore a line change and hold its outputs
  task t_freeze;
    @(posedge core_clk);
    clk_en <= 1'b0;
    dma_end_req <= 4'h0;
    mask <= 4'hf;
    settle(3, 1'b0);
    chk(cpu_irq_req, 1'b1);
    @(posedge core_clk);
    clk_en <= 1'b1;
    settle(3, 1'b1);
    rd(4'h0, 32'h0);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      summarize;
    end
  end
  initial begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    t_flags;
    t_accept;
    t_irq;
    t_freeze;
    summarize;
  end
endmodule

//--- design/irqfs_consts.vh
`ifndef IRQFS_CONSTS_VH
`define IRQFS_CONSTS_VH
`define IRQFS_ADDR_FLAGS_A 4'h0
`define IRQFS_ADDR_FLAGS_B 4'h1
`define IRQFS_ADDR_PRIO_A 4'h2
`define IRQFS_ADDR_PRIO_B 4'h3
`define IRQFS_ADDR_PRIO_C 4'h4
`define IRQFS_ADDR_EVENT 4'h5
`define IRQFS_ADDR_EVENT_ALT 4'h6
`define IRQFS_ADDR_IRQ_STATUS 4'h7
`define IRQFS_ADDR_IRQ_MASK 4'h8
`define IRQFS_FLAGS_RESET 8'h00
`define IRQFS_FLAGS_B_USED 8'h1f
`define IRQFS_NUM_SRC 13
`define IRQFS_CODE_BASE 12'h400
`define IRQFS_CODE_STEP 6'h20
`define IRQFS_HANDLER_OFFSET 32'h00000600
`define IRQFS_SR_HOLD 28
`define IRQFS_SR_BANK 29
`define IRQFS_SR_PRIV 30
`define IRQFS_SR_MASK_LO 4
`define IRQFS_EV_ACCEPT 0
`define IRQFS_EV_ENTRY 1
`endif

//--- design/irqfs_sequencer.v
// Behaviour
// - Flags A: infrared bits 7-4, DMA 3-0
// - Flags clear on reset, otherwise follow the request lines while clk_en is high
// - Flag bit one while request present
// - Flags B: converter bit 4, FIFO serial 3-0
// - Flags B bits 7-5 read zero
// - Pick highest programmed level, others wait
// - Ties go to fixed default order
// - Accept only when level exceeds mask
// - Pending pin low while accepted request stands
// - Pending pin high when mask covers source
// - Synchronous; CPU takes at instruction boundary
// - Source code loaded into both event registers
// - Entry saves status and program counter
// - Entry jumps to vector base plus offset
// - Entry leaves priority mask unchanged
`timescale 1ns/10ps
`include "irqfs_consts.vh"
module irqfs_sequencer (
  input wire core_clk,
  input wire srst,
  input wire clk_en,
  input wire [3:0] dma_end_req,
  input wire [3:0] infrared_req,
  input wire converter_done_req,
  input wire [3:0] fifo_serial_req,
  input wire [3:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  input wire [31:0] cpu_status,
  input wire [31:0] cpu_pc,
  input wire [31:0] vector_base,
  input wire insn_boundary,
  output reg cpu_irq_req,
  output reg pending_indicator_pin_n,
  output reg entry_strobe,
  output reg [31:0] saved_status_register,
  output reg [31:0] saved_program_counter,
  output reg [31:0] next_status,
  output reg [31:0] entry_target,
  output reg irq_out
);
  reg [7:0] peripheral_request_flags_a;
  reg [7:0] peripheral_request_flags_b;
  reg [15:0] priority_level_reg_a;
  reg [15:0] priority_level_reg_b;
  reg [15:0] priority_level_reg_c;
  reg [11:0] event_code_reg;
  reg [11:0] event_code_reg_alt;
  reg [1:0] irq_status;
  reg [1:0] irq_mask;
  reg [12:0] src_all;
  reg [3:0] src_level [0:12];
  reg [3:0] best_level;
  reg [3:0] best_idx;
  reg found;
  reg [3:0] sel_level;
  reg [3:0] sel_idx;
  reg sel_valid;
  reg [1:0] ev_set;
  integer i;
  wire [3:0] priority_mask_field;
  wire accept_ok;
  wire take_now;
  wire [1:0] clr_bits;
  assign priority_mask_field = cpu_status[`IRQFS_SR_MASK_LO+3:`IRQFS_SR_MASK_LO];
  // Source order index 0 wins ties: DMA 0-3, infrared err..tx, converter, FIFO err..tx
  always @* begin
    src_all = {fifo_serial_req[3:0], converter_done_req, peripheral_request_flags_a[7:4],
      peripheral_request_flags_a[3:0]};
    src_all[12:9] = peripheral_request_flags_b[3:0];
    src_all[8] = peripheral_request_flags_b[4];
    for (i = 0; i < 4; i = i + 1) begin
      src_level[i] = priority_level_reg_a[3:0];
      src_level[4+i] = priority_level_reg_a[7:4];
      src_level[9+i] = priority_level_reg_b[3:0];
    end
    src_level[8] = priority_level_reg_a[11:8];
  end
  // Strictly-greater compare keeps the earlier, higher default source on ties
  always @* begin
    best_level = 4'h0;
    best_idx = 4'h0;
    found = 1'b0;
    for (i = 0; i < `IRQFS_NUM_SRC; i = i + 1) begin
      if (src_all[i] && (src_level[i] > best_level)) begin
        best_level = src_level[i];
        best_idx = i[3:0];
        found = 1'b1;
      end else if (src_all[i] && !found && (src_level[i] == best_level)) begin
        best_idx = i[3:0];
      end
    end
  end
  assign accept_ok = found && (best_level > priority_mask_field);
  // Entry is recorded only on a boundary while the hold bit is clear
  assign take_now = cpu_irq_req && insn_boundary && !cpu_status[`IRQFS_SR_HOLD];
  assign clr_bits = (reg_wr && reg_addr == `IRQFS_ADDR_IRQ_STATUS) ? reg_wdata[1:0] : 2'b00;
  always @* begin
    ev_set = 2'b00;
    ev_set[`IRQFS_EV_ACCEPT] = accept_ok && !sel_valid;
    ev_set[`IRQFS_EV_ENTRY] = take_now;
  end
  always @(posedge core_clk) begin
    if (srst) begin
      peripheral_request_flags_a <= `IRQFS_FLAGS_RESET;
      peripheral_request_flags_b <= `IRQFS_FLAGS_RESET;
      priority_level_reg_a <= 16'h0000;
      priority_level_reg_b <= 16'h0000;
      priority_level_reg_c <= 16'h0000;
      event_code_reg <= 12'h000;
      event_code_reg_alt <= 12'h000;
      irq_status <= 2'b00;
      irq_mask <= 2'b00;
      sel_level <= 4'h0;
      sel_idx <= 4'h0;
      sel_valid <= 1'b0;
      cpu_irq_req <= 1'b0;
      pending_indicator_pin_n <= 1'b1;
      entry_strobe <= 1'b0;
      saved_status_register <= 32'h00000000;
      saved_program_counter <= 32'h00000000;
      next_status <= 32'h00000000;
      entry_target <= 32'h00000000;
      irq_out <= 1'b0;
      reg_rdata <= 32'h00000000;
    end else if (clk_en) begin
      // Same-clock sources: flags mirror the lines, so clearing at source clears here
      peripheral_request_flags_a <= {infrared_req, dma_end_req};
      peripheral_request_flags_b <= {3'b000, converter_done_req, fifo_serial_req}
        & `IRQFS_FLAGS_B_USED;
      if (reg_wr) begin
        case (reg_addr)
          `IRQFS_ADDR_PRIO_A: priority_level_reg_a <= reg_wdata[15:0];
          `IRQFS_ADDR_PRIO_B: priority_level_reg_b <= reg_wdata[15:0];
          `IRQFS_ADDR_PRIO_C: priority_level_reg_c <= reg_wdata[15:0];
          `IRQFS_ADDR_IRQ_MASK: irq_mask <= reg_wdata[1:0];
          default: ;
        endcase
      end
      // Set beats clear in the same cycle
      irq_status <= (irq_status & ~clr_bits) | ev_set;
      irq_out <= |(((irq_status & ~clr_bits) | ev_set) & irq_mask);
      sel_valid <= accept_ok;
      sel_level <= best_level;
      sel_idx <= best_idx;
      cpu_irq_req <= accept_ok;
      // Rises on clear or on masking, regardless of the hold bit
      pending_indicator_pin_n <= !accept_ok;
      entry_strobe <= take_now;
      if (take_now) begin
        event_code_reg <= `IRQFS_CODE_BASE + sel_idx * `IRQFS_CODE_STEP;
        event_code_reg_alt <= `IRQFS_CODE_BASE + sel_idx * `IRQFS_CODE_STEP;
        saved_status_register <= cpu_status;
        saved_program_counter <= cpu_pc;
        next_status <= cpu_status | (32'h1 << `IRQFS_SR_HOLD) | (32'h1 << `IRQFS_SR_PRIV)
          | (32'h1 << `IRQFS_SR_BANK);
        entry_target <= vector_base + `IRQFS_HANDLER_OFFSET;
      end
      if (reg_rd) begin
        case (reg_addr)
          `IRQFS_ADDR_FLAGS_A: reg_rdata <= {24'h000000, peripheral_request_flags_a};
          `IRQFS_ADDR_FLAGS_B: reg_rdata <= {24'h000000, peripheral_request_flags_b};
          `IRQFS_ADDR_PRIO_A: reg_rdata <= {16'h0000, priority_level_reg_a};
          `IRQFS_ADDR_PRIO_B: reg_rdata <= {16'h0000, priority_level_reg_b};
          `IRQFS_ADDR_PRIO_C: reg_rdata <= {16'h0000, priority_level_reg_c};
          `IRQFS_ADDR_EVENT: reg_rdata <= {20'h00000, event_code_reg};
          `IRQFS_ADDR_EVENT_ALT: reg_rdata <= {20'h00000, event_code_reg_alt};
          `IRQFS_ADDR_IRQ_STATUS: reg_rdata <= {30'h00000000, irq_status};
          `IRQFS_ADDR_IRQ_MASK: reg_rdata <= {30'h00000000, irq_mask};
          default: reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule
